//--- redriver_status_swing.sv
// Link status, transmitter swing and adaptive equalizer result registers
`include "rss_regs.svh"

module redriver_status_swing_regs #(
    parameter int SETTLE_CYCLES = `RSS_SETTLE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic enter_link_active,
    input wire logic enter_low_power,
    input wire logic enter_disconnect,
    input wire logic compliance_mode,
    input wire logic eq_hit,
    input wire logic sweep_done,
    input wire logic sweep_long_channel,
    input wire logic [3:0] sweep_best_code,
    input wire logic [3:0] port1_rx_eq_select,
    input wire logic [3:0] long_channel_eq_code,
    output logic [3:0] applied_eq_code,
    output logic adaptation_busy,
    output logic [1:0] lfps_downstream_swing,
    output logic [1:0] display_path_swing,
    output logic [1:0] downstream_tx_swing,
    output logic [1:0] upstream_tx_swing,
    output logic [1:0] upstream_limited_swing,
    output logic upstream_limited_mode_enable,
    output logic irq
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    initial begin
        if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin
            $error("SETTLE_CYCLES must lie in 1..65535");
        end
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    // Code 0 drives the top level, code 3 the bottom one
    function automatic rss_pkg::swing_level_type swing_level(
        input logic [1:0] code
    );
        swing_level = rss_pkg::swing_level_type'(2'h3 - code);
    endfunction

    function automatic logic [7:0] link_flags(input rss_pkg::state_type s);
        logic [7:0] v;
        v = 8'h00;
        // Channel length is masked off when adaptation is disabled
        v[`RSS_LS_CHANNEL_LENGTH] = s.channel_length_eq_flag &
            s.aeq_control[`RSS_CTL_ENABLE];
        v[`RSS_LS_ADAPT_COMPLETE] = s.adaptation_complete_flag;
        v[`RSS_LS_HIT_WRAP] = s.hit_counter_wrap_flag;
        v[`RSS_LS_COMPLIANCE] = compliance_mode;
        v[`RSS_LS_LINK_ACTIVE] = s.link_active_state_flag;
        v[`RSS_LS_LOW_POWER] = s.low_power_state_flag;
        v[`RSS_LS_DISCONNECTED] = s.disconnected_flag;
        return v;
    endfunction

    rss_pkg::state_type cur_q;
    rss_pkg::state_type nxt_d;

    logic adapt_en;
    logic two_setting;
    logic start_auto;
    logic start_forced;
    logic settle_expire;
    logic [7:0] irq_events;

    always_comb begin
        adapt_en = cur_q.aeq_control[`RSS_CTL_ENABLE];
        // Method codes with bit 0 clear select the two-setting scheme
        two_setting = ~cur_q.aeq_control[`RSS_CTL_METHOD_LSB];
        start_auto = adapt_en & enter_link_active;
        start_forced = cur_q.aeq_control[`RSS_CTL_FORCED_EN] &
            cur_q.aeq_control[`RSS_CTL_FORCED_TRIG];
        settle_expire = (cur_q.state == rss_pkg::ST_SETTLE) &&
            (cur_q.settle_cnt == 16'(SETTLE_CYCLES - 1));
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        nxt_d = cur_q;
        irq_events = 8'h00;

        // Link state tracking: entering one state replaces the others
        if (enter_disconnect) begin
            nxt_d.disconnected_flag = 1'b1;
            nxt_d.link_active_state_flag = 1'b0;
            nxt_d.low_power_state_flag = 1'b0;
            irq_events[`RSS_IRQ_DISCONNECT] = 1'b1;
        end else if (enter_low_power) begin
            nxt_d.low_power_state_flag = 1'b1;
            nxt_d.link_active_state_flag = 1'b0;
            nxt_d.disconnected_flag = 1'b0;
            irq_events[`RSS_IRQ_LOW_POWER] = 1'b1;
        end else if (enter_link_active) begin
            nxt_d.link_active_state_flag = 1'b1;
            nxt_d.low_power_state_flag = 1'b0;
            nxt_d.disconnected_flag = 1'b0;
            irq_events[`RSS_IRQ_LINK_ACTIVE] = 1'b1;
        end

        // Adaptation sequencer
        case (cur_q.state)
            rss_pkg::ST_IDLE: begin
                if (start_auto || start_forced) begin
                    nxt_d.state = rss_pkg::ST_SETTLE;
                    nxt_d.settle_cnt = 16'h0000;
                    nxt_d.settle_done = 1'b0;
                    nxt_d.hit_cnt = 13'h0000;
                    nxt_d.hit_counter_wrap_flag = 1'b0;
                    nxt_d.adaptation_complete_flag = 1'b0;
                end
            end
            rss_pkg::ST_SETTLE: begin
                if (settle_expire) begin
                    nxt_d.settle_done = 1'b1;
                    nxt_d.state = rss_pkg::ST_MEASURE;
                    irq_events[`RSS_IRQ_SETTLE_DONE] = 1'b1;
                end else begin
                    nxt_d.settle_cnt = cur_q.settle_cnt + 16'h0001;
                end
            end
            rss_pkg::ST_MEASURE: begin
                if (eq_hit) begin
                    nxt_d.hit_cnt = cur_q.hit_cnt + 13'h0001;
                    if (cur_q.hit_cnt == 13'h1FFF) begin
                        nxt_d.hit_counter_wrap_flag = 1'b1;
                        irq_events[`RSS_IRQ_HIT_WRAP] = 1'b1;
                    end
                end
                if (sweep_done) begin
                    nxt_d.state = rss_pkg::ST_FINISH;
                    if (two_setting) begin
                        nxt_d.channel_length_eq_flag =
                            sweep_long_channel;
                        nxt_d.chosen_eq_code = sweep_long_channel ?
                            long_channel_eq_code :
                            port1_rx_eq_select;
                    end else begin
                        nxt_d.channel_length_eq_flag = 1'b0;
                        nxt_d.chosen_eq_code = sweep_best_code;
                    end
                end
            end
            rss_pkg::ST_FINISH: begin
                nxt_d.state = rss_pkg::ST_IDLE;
                nxt_d.adaptation_complete_flag = 1'b1;
                // Hardware drops the force trigger once done
                nxt_d.aeq_control[`RSS_CTL_FORCED_TRIG] = 1'b0;
                irq_events[`RSS_IRQ_ADAPT_DONE] = 1'b1;
            end
            default: begin
                nxt_d.state = rss_pkg::ST_IDLE;
            end
        endcase

        // Disabling adaptation zeroes the length result
        if (!adapt_en) begin
            nxt_d.channel_length_eq_flag = 1'b0;
        end

        // Software override is mirrored into the chosen code
        if (cur_q.aeq_control[`RSS_CTL_OVERRIDE]) begin
            nxt_d.chosen_eq_code = cur_q.forced_eq_code;
        end

        // Register writes; status fields take none
        if (wr_en) begin
            if (addr == `RSS_OFF_TX_SWING_CONTROL) begin
                nxt_d.tx_swing_control = wr_data;
            end else if (addr == `RSS_OFF_AEQ_CONTROL) begin
                // Trigger set by software is kept; clear comes from hardware
                nxt_d.aeq_control = (wr_data & `RSS_CTL_MASK) |
                    (nxt_d.aeq_control &
                    (8'h01 << `RSS_CTL_FORCED_TRIG) &
                    {8{cur_q.state != rss_pkg::ST_FINISH}});
            end else if (addr == `RSS_OFF_FORCED_EQ) begin
                nxt_d.forced_eq_code = wr_data[3:0];
            end else if (addr == `RSS_OFF_IRQ_ENABLE) begin
                nxt_d.irq_enable = wr_data & `RSS_IRQ_MASK;
            end else if (addr == `RSS_OFF_IRQ_CLEAR) begin
                nxt_d.irq_status = cur_q.irq_status & ~wr_data;
            end
        end

        // A new event outranks a clear in the same cycle
        nxt_d.irq_status = nxt_d.irq_status | irq_events;

        // Read data is valid the cycle after the strobe only
        nxt_d.rd_data = 8'h00;
        if (rd_en) begin
            if (addr == `RSS_OFF_LINK_STATE_FLAGS) begin
                nxt_d.rd_data = link_flags(cur_q);
            end else if (addr == `RSS_OFF_TX_SWING_CONTROL) begin
                nxt_d.rd_data = cur_q.tx_swing_control;
            end else if (addr == `RSS_OFF_ADAPTIVE_EQ_RESULT) begin
                nxt_d.rd_data = {3'h0, cur_q.settle_done,
                    cur_q.chosen_eq_code};
            end else if (addr == `RSS_OFF_AEQ_CONTROL) begin
                nxt_d.rd_data = cur_q.aeq_control;
            end else if (addr == `RSS_OFF_FORCED_EQ) begin
                nxt_d.rd_data = {4'h0, cur_q.forced_eq_code};
            end else if (addr == `RSS_OFF_IRQ_STATUS) begin
                nxt_d.rd_data = cur_q.irq_status;
            end else if (addr == `RSS_OFF_IRQ_ENABLE) begin
                nxt_d.rd_data = cur_q.irq_enable;
            end else begin
                nxt_d.rd_data = 8'h00;
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_q.state <= rss_pkg::ST_IDLE;
            cur_q.settle_cnt <= 16'h0000;
            cur_q.hit_cnt <= 13'h0000;
            cur_q.channel_length_eq_flag <= 1'b0;
            cur_q.adaptation_complete_flag <= 1'b1;
            cur_q.hit_counter_wrap_flag <= 1'b0;
            cur_q.link_active_state_flag <= 1'b0;
            cur_q.low_power_state_flag <= 1'b0;
            cur_q.disconnected_flag <= 1'b1;
            cur_q.settle_done <= 1'b0;
            cur_q.chosen_eq_code <= 4'h0;
            cur_q.tx_swing_control <= `RSS_RST_TX_SWING_CONTROL;
            cur_q.aeq_control <= `RSS_RST_AEQ_CONTROL;
            cur_q.forced_eq_code <= 4'h0;
            cur_q.irq_status <= 8'h00;
            cur_q.irq_enable <= `RSS_RST_IRQ_ENABLE;
            cur_q.rd_data <= 8'h00;
        end else begin
            cur_q <= nxt_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_comb begin
        rd_data = cur_q.rd_data;
        applied_eq_code = cur_q.chosen_eq_code;
        adaptation_busy = ~cur_q.adaptation_complete_flag;
        lfps_downstream_swing = swing_level(
            cur_q.tx_swing_control[`RSS_SW_LFPS_LSB +: 2]);
        display_path_swing = swing_level(
            cur_q.tx_swing_control[`RSS_SW_DISPLAY_LSB +: 2]);
        downstream_tx_swing = swing_level(
            cur_q.tx_swing_control[`RSS_SW_DOWNSTREAM_LSB +: 2]);
        upstream_limited_mode_enable =
            cur_q.aeq_control[`RSS_CTL_LIMITED];
        // The same field feeds whichever upstream driver is in use
        upstream_tx_swing = upstream_limited_mode_enable ? 2'h0 :
            swing_level(cur_q.tx_swing_control[1:0]);
        upstream_limited_swing = upstream_limited_mode_enable ?
            swing_level(cur_q.tx_swing_control[1:0]) : 2'h0;
        irq = |(cur_q.irq_status & cur_q.irq_enable);
    end

endmodule

//--- rss_checker.sv
// Port-level assertions for the status and swing register slice
module rss_checker #(
    parameter int SETTLE_CYCLES = 4
) (
    input logic sys_clk,
    input logic rst_n,
    input logic [7:0] addr,
    input logic [7:0] wr_data,
    input logic wr_en,
    input logic rd_en,
    input logic [7:0] rd_data,
    input logic enter_link_active,
    input logic enter_low_power,
    input logic enter_disconnect,
    input logic sweep_done,
    input logic [3:0] applied_eq_code,
    input logic adaptation_busy,
    input logic [1:0] lfps_downstream_swing,
    input logic [1:0] display_path_swing,
    input logic [1:0] downstream_tx_swing,
    input logic [1:0] upstream_tx_swing,
    input logic [1:0] upstream_limited_swing,
    input logic upstream_limited_mode_enable
);
    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence swing_wr;
        wr_en && addr == 8'h32;
    endsequence

    a_read_idle_zero: assert property (
        !$past(rd_en) |-> rd_data == 8'h00) else $error("rd_data not idle");
    a_lfps_swing_map: assert property (
        swing_wr |=> lfps_downstream_swing == 2'h3 - $past(wr_data[7:6]))
        else $error("lfps swing level wrong");
    a_display_swing_map: assert property (
        swing_wr |=> display_path_swing == 2'h3 - $past(wr_data[5:4]))
        else $error("display swing level wrong");
    a_down_swing_map: assert property (
        swing_wr |=> downstream_tx_swing == 2'h3 - $past(wr_data[3:2]))
        else $error("downstream swing level wrong");
    a_up_swing_map: assert property (
        swing_wr |=> (upstream_limited_mode_enable ? upstream_limited_swing
        : upstream_tx_swing) == 2'h3 - $past(wr_data[1:0]))
        else $error("upstream swing level wrong");
    a_limited_split: assert property (
        upstream_limited_mode_enable |-> upstream_tx_swing == 2'h0)
        else $error("linear swing active in limited mode");
    a_busy_end_sweep: assert property (
        $fell(adaptation_busy) |-> $past(sweep_done, 2))
        else $error("adaptation ended without sweep");
    a_settle_min: assert property (
        $rose(adaptation_busy) |-> adaptation_busy [*4])
        else $error("adaptation too short");
    a_disc_flag: assert property (
        rd_en && addr == 8'h24 && $past(enter_disconnect)
        |=> rd_data[2:0] == 3'b001) else $error("disconnect flag wrong");
    a_low_power_flag: assert property (
        rd_en && addr == 8'h24 && $past(enter_low_power)
        && !$past(enter_disconnect) |=> rd_data[2:0] == 3'b010)
        else $error("low power flag wrong");
    a_link_active_flag: assert property (
        rd_en && addr == 8'h24 && $past(enter_link_active)
        && !$past(enter_low_power) && !$past(enter_disconnect)
        |=> rd_data[2:0] == 3'b100) else $error("link active flag wrong");
    a_code_readback: assert property (
        $past(rd_en) && $past(addr) == 8'h3B
        |-> rd_data[3:0] == $past(applied_eq_code))
        else $error("result register disagrees with code");

    c_adapt_done: cover property ($fell(adaptation_busy));
    c_swing_write: cover property (swing_wr);
    c_disc_read: cover property (rd_en && $past(enter_disconnect));
endmodule

bind redriver_status_swing_regs rss_checker #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
) rss_checker_i (
    .sys_clk,
    .rst_n,
    .addr,
    .wr_data,
    .wr_en,
    .rd_en,
    .rd_data,
    .enter_link_active,
    .enter_low_power,
    .enter_disconnect,
    .sweep_done,
    .applied_eq_code,
    .adaptation_busy,
    .lfps_downstream_swing,
    .display_path_swing,
    .downstream_tx_swing,
    .upstream_tx_swing,
    .upstream_limited_swing,
    .upstream_limited_mode_enable
);

//--- rss_pkg.sv
// Types shared by the redriver status and swing register slice
package rss_pkg;

    // ************************************************************
    // Adaptation sequencer states
    // ************************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETTLE = 4'b0010,
        ST_MEASURE = 4'b0100,
        ST_FINISH = 4'b1000
    } adapt_state_type;

    // Linearity levels driven to the analog transmitters
    typedef enum logic [1:0] {
        SWING_LEVEL_BOTTOM = 2'h0,
        SWING_LEVEL_LOWER = 2'h1,
        SWING_LEVEL_UPPER = 2'h2,
        SWING_LEVEL_TOP = 2'h3
    } swing_level_type;

    typedef struct packed {
        adapt_state_type state;
        logic [15:0] settle_cnt;
        logic [12:0] hit_cnt;
        logic channel_length_eq_flag;
        logic adaptation_complete_flag;
        logic hit_counter_wrap_flag;
        logic link_active_state_flag;
        logic low_power_state_flag;
        logic disconnected_flag;
        logic settle_done;
        logic [3:0] chosen_eq_code;
        logic [7:0] tx_swing_control;
        logic [7:0] aeq_control;
        logic [3:0] forced_eq_code;
        logic [7:0] irq_status;
        logic [7:0] irq_enable;
        logic [7:0] rd_data;
    } state_type;

endpackage

//--- rss_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RSS_OFF_LINK_STATE_FLAGS 8'h24
`define RSS_OFF_TX_SWING_CONTROL 8'h32
`define RSS_OFF_ADAPTIVE_EQ_RESULT 8'h3B
`define RSS_OFF_AEQ_CONTROL 8'h40
`define RSS_OFF_FORCED_EQ 8'h41
`define RSS_OFF_IRQ_STATUS 8'h42
`define RSS_OFF_IRQ_CLEAR 8'h43
`define RSS_OFF_IRQ_ENABLE 8'h44

// ****************************************************************
// Reset values
// ****************************************************************
`define RSS_RST_LINK_STATE_FLAGS 8'h41
`define RSS_RST_TX_SWING_CONTROL 8'h40
`define RSS_RST_ADAPTIVE_EQ_RESULT 8'h00
`define RSS_RST_AEQ_CONTROL 8'h00
`define RSS_RST_FORCED_EQ 8'h00
`define RSS_RST_IRQ_ENABLE 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define RSS_LS_CHANNEL_LENGTH 7
`define RSS_LS_ADAPT_COMPLETE 6
`define RSS_LS_HIT_WRAP 5
`define RSS_LS_COMPLIANCE 3
`define RSS_LS_LINK_ACTIVE 2
`define RSS_LS_LOW_POWER 1
`define RSS_LS_DISCONNECTED 0
`define RSS_SW_LFPS_LSB 6
`define RSS_SW_DISPLAY_LSB 4
`define RSS_SW_DOWNSTREAM_LSB 2
`define RSS_SW_UPSTREAM_LSB 0
`define RSS_RES_SETTLE_DONE 4
`define RSS_CTL_ENABLE 0
`define RSS_CTL_METHOD_LSB 1
`define RSS_CTL_FORCED_EN 3
`define RSS_CTL_FORCED_TRIG 4
`define RSS_CTL_OVERRIDE 5
`define RSS_CTL_LIMITED 6
`define RSS_CTL_MASK 8'h7F

// Interrupt bit layout
`define RSS_IRQ_LINK_ACTIVE 0
`define RSS_IRQ_LOW_POWER 1
`define RSS_IRQ_DISCONNECT 2
`define RSS_IRQ_ADAPT_DONE 3
`define RSS_IRQ_HIT_WRAP 4
`define RSS_IRQ_SETTLE_DONE 5
`define RSS_IRQ_MASK 8'h3F

// ****************************************************************
// Timing
// ****************************************************************
`define RSS_CLK_PERIOD_NS 10
`define RSS_SETTLE_TIME_NS 1000
`define RSS_SETTLE_CYCLES \
    ((`RSS_SETTLE_TIME_NS + `RSS_CLK_PERIOD_NS - 1) / `RSS_CLK_PERIOD_NS)

`endif

//--- tb_top.sv
// Self-checking bench for the status and swing register slice
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SETTLE = 4;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [2:0] ev = 3'h0;
    logic compliance_mode = 1'b0;
    logic eq_hit = 1'b0;
    logic sweep_done = 1'b0;
    logic sweep_long_channel = 1'b0;
    logic [3:0] sweep_best_code = 4'h3;
    logic [3:0] port1_rx_eq_select = 4'h5;
    logic [3:0] long_channel_eq_code = 4'hA;
    logic [7:0] rd_data;
    logic [3:0] applied_eq_code;
    logic adaptation_busy, irq, upstream_limited_mode_enable;
    logic [1:0] lfps_downstream_swing, display_path_swing;
    logic [1:0] downstream_tx_swing, upstream_tx_swing, upstream_limited_swing;
    int miscompares = 0;
    int cmp_count = 0;

    always #5 sys_clk = ~sys_clk;

    redriver_status_swing_regs #(
        .SETTLE_CYCLES(SETTLE)
    ) redriver_status_swing_regs_i (
        .sys_clk,
        .rst_n,
        .addr,
        .wr_data,
        .wr_en,
        .rd_en,
        .rd_data,
        .enter_link_active(ev[0]),
        .enter_low_power(ev[1]),
        .enter_disconnect(ev[2]),
        .compliance_mode,
        .eq_hit,
        .sweep_done,
        .sweep_long_channel,
        .sweep_best_code,
        .port1_rx_eq_select,
        .long_channel_eq_code,
        .applied_eq_code,
        .adaptation_busy,
        .lfps_downstream_swing,
        .display_path_swing,
        .downstream_tx_swing,
        .upstream_tx_swing,
        .upstream_limited_swing,
        .upstream_limited_mode_enable,
        .irq
    );

    // ************************************************************
    // Access and compare tasks
    // ************************************************************
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge sys_clk);
        wr_en <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        check($sformatf("reg_%h", a), rd_data, exp);
    endtask

    // Read starts in the cycle right after the event, so flag updates
    // are seen before any later traffic can disturb them
    task automatic pulse(input int i, input logic [7:0] exp);
        @(posedge sys_clk);
        ev[i] <= 1'b1;
        @(posedge sys_clk);
        ev <= 3'h0;
        rd_en <= 1'b1;
        addr <= 8'h24;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        check("link_flags", rd_data, exp);
    endtask

    task automatic swing(input logic [7:0] v, input logic lim);
        wr(8'h32, v);
        check("lfps", lfps_downstream_swing, 8'h3 - v[7:6]);
        check("display", display_path_swing, 8'h3 - v[5:4]);
        check("down", downstream_tx_swing, 8'h3 - v[3:2]);
        check("up", upstream_tx_swing, lim ? 8'h0 : 8'h3 - v[1:0]);
        check("up_lim", upstream_limited_swing,
              lim ? 8'h3 - v[1:0] : 8'h0);
        rd(8'h32, v);
    endtask

    task automatic adapt(input logic lng, input logic [3:0] code,
                         input logic [3:0] prev, input logic hits);
        pulse(0, 8'h04);
        check("busy", adaptation_busy, 8'h1);
        repeat (SETTLE + 2) @(posedge sys_clk);
        rd(8'h3B, {4'h1, prev});
        if (hits) begin
            @(posedge sys_clk);
            eq_hit <= 1'b1;
            repeat (8191) @(posedge sys_clk);
            eq_hit <= 1'b0;
            rd(8'h24, 8'h04);
            @(posedge sys_clk);
            eq_hit <= 1'b1;
            @(posedge sys_clk);
            eq_hit <= 1'b0;
            rd(8'h24, 8'h24);
        end
        @(posedge sys_clk);
        sweep_done <= 1'b1;
        sweep_long_channel <= lng;
        @(posedge sys_clk);
        sweep_done <= 1'b0;
        for (int n = 0; n < 8 && adaptation_busy !== 1'b0; n++) begin
            @(posedge sys_clk);
        end
        #1;
        check("busy", adaptation_busy, 8'h0);
        rd(8'h24, {lng, 1'b1, hits, 5'h04});
        rd(8'h3B, {4'h1, code});
    endtask

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        check("lfps", lfps_downstream_swing, 8'h2);
        rd(8'h24, 8'h41);
        rd(8'h32, 8'h40);
        rd(8'h3B, 8'h00);
        rd(8'h10, 8'h00);
        for (int c = 0; c < 4; c++) begin
            swing(8'h55 * c, 1'b0);
        end
        wr(8'h40, 8'h40);
        swing(8'hE4, 1'b1);
        wr(8'h24, 8'h00);
        wr(8'h3B, 8'hFF);
        rd(8'h24, 8'h41);
        rd(8'h3B, 8'h00);
        wr(8'h43, 8'hFF);
        wr(8'h44, 8'h04);
        pulse(0, 8'h44);
        check("irq", irq, 8'h0);
        @(posedge sys_clk);
        compliance_mode <= 1'b1;
        pulse(1, 8'h4A);
        pulse(2, 8'h49);
        check("irq", irq, 8'h1);
        rd(8'h42, 8'h07);
        wr(8'h43, 8'h04);
        check("irq", irq, 8'h0);
        rd(8'h42, 8'h03);
        wr(8'h44, 8'h00);
        @(posedge sys_clk);
        compliance_mode <= 1'b0;
        wr(8'h40, 8'h01);
        adapt(1'b0, 4'h5, 4'h0, 1'b0);
        adapt(1'b1, 4'hA, 4'h5, 1'b1);
        wr(8'h40, 8'h00);
        rd(8'h24, 8'h64);
        wr(8'h41, 8'h09);
        wr(8'h40, 8'h20);
        rd(8'h3B, 8'h19);
        check("code", applied_eq_code, 8'h09);
        wr(8'h40, 8'h03);
        adapt(1'b0, 4'h3, 4'h9, 1'b0);
        // Forced run with auto adaptation off; hardware drops the trigger
        wr(8'h40, 8'h18);
        repeat (SETTLE + 4) @(posedge sys_clk);
        sweep_done <= 1'b1;
        @(posedge sys_clk);
        sweep_done <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rd(8'h40, 8'h08);
        rd(8'h24, 8'h44);
        rd(8'h3B, 8'h15);
        close_out();
    end

    initial begin
        #500000;
        miscompares++;
        close_out();
    end
endmodule
